/* File: rtl/wdt_pkg.sv */
// Constants and carrier types for the watchdog pulse timer.
// Assumes a single 20 MHz core clock and a synchronous active-low reset.
package wdt_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;     // Core clock period
  localparam int TICK_TIME_NS  = 100000; // One counter unit, 100 us
  localparam int PULSE_TIME_NS = 30000;  // Timeout pulse, about 30 us
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES  =
    (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int          CNT_W       = 16;       // Initial value width
  localparam int          DIV_W       = 12;       // Tick divider width
  localparam int          PW_W        = 10;       // Pulse counter width
  localparam logic [15:0] CNT_RESET   = 16'h0000; // Counter at reset
  localparam logic        MODE_STOP   = 1'b0;     // Command selector stop
  localparam logic        MODE_START  = 1'b1;     // Command selector start

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        valid; // One-cycle command strobe
    logic        mode;  // 1 start, 0 stop
    logic [15:0] init;  // Initial value in 100 us units
  } wdt_cmd_s;

  typedef struct packed {
    logic running; // 1 counting down, 0 stopped
    logic error;   // 1 status not valid
  } wdt_stat_s;

endpackage

/* File: rtl/wdt_tick_div.sv */
// Divider giving a one-cycle enable every 100 us of core clock.
// Assumes clr is from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module wdt_tick_div #(
  parameter int DIV = wdt_pkg::TICK_CYCLES // Core cycles per tick
) (
  input  wire logic core_clk, // Core clock
  input  wire logic resetn,   // Synchronous reset, active low
  input  wire logic clr,      // Restart phase
  input  wire logic en,       // Count enable
  output logic      tick      // One-cycle tick pulse
);
  import wdt_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DIV_W-1:0] cnt; // Cycles into tick
    logic             tick;
  } div_s;

  div_s st_q;
  div_s st_d;

  // Next-state of divider
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (clr || !en) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == DIV_W'(DIV - 1)) begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + DIV_W'(1);
    end
  end

  // Register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

  a_tick_single : assert property (
    @(posedge core_clk) disable iff (!resetn)
    tick |=> !tick)
    else $error("tick longer than one cycle");

endmodule
`default_nettype wire

/* File: rtl/wdt_pulse_timer.sv */
// Watchdog down-counter with repeating active-low timeout pulse.
// Assumes commands arrive as one-cycle strobes on core_clk and a
// fault input from the same domain; pin output goes to bus logic.
`timescale 1ns/1ns
`default_nettype none
module watchdog_pulse_timer #(
  parameter int TICK_CYC  = wdt_pkg::TICK_CYCLES,  // Cycles per unit
  parameter int PULSE_CYC = wdt_pkg::PULSE_CYCLES  // Pulse length
) (
  input  wire logic         core_clk,        // 20 MHz clock
  input  wire logic         resetn,          // Sync reset, active low
  input  wire wdt_pkg::wdt_cmd_s cmd,        // Start or stop command
  input  wire logic         fault,           // Counter fault present
  output wdt_pkg::wdt_stat_s status,         // Running and error flags
  output logic              timeout_pulse_n  // Count-out line, low
);
  import wdt_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [0:0] {
    S_STOP = 1'b0, // Halted
    S_RUN  = 1'b1  // Counting down
  } run_e;

  typedef struct packed {
    run_e             run;     // Run state
    logic [CNT_W-1:0] reload;  // Last written initial value
    logic [CNT_W-1:0] cnt;     // Remaining units
    logic [PW_W-1:0]  pw;      // Pulse cycles remaining
    logic             pin_n;   // Registered timeout line
    logic             err;     // Registered error flag
    logic [PW_W:0]    low;     // Cycles the line has been low
  } wdt_s;

  wdt_s st_q;
  wdt_s st_d;

  logic tick;   // 100 us enable
  logic restart; // Start command accepted

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // Command strobe asking for a load and start
  function automatic logic is_start(input wdt_cmd_s c);
    return c.valid && (c.mode == MODE_START);
  endfunction

  // Command strobe asking for a halt
  function automatic logic is_stop(input wdt_cmd_s c);
    return c.valid && (c.mode == MODE_STOP);
  endfunction

  // Last unit of the count; zero behaves as one
  function automatic logic is_last(input logic [CNT_W-1:0] c);
    return c <= CNT_W'(1);
  endfunction

  assign restart = is_start(cmd);

  // ****************************************************************
  // Unit divider
  // ****************************************************************
  wdt_tick_div #(
    .DIV (TICK_CYC)
  ) u_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (restart),
    .en       (st_q.run == S_RUN),
    .tick     (tick)
  );

  // Next-state logic
  always_comb begin
    st_d     = st_q;
    st_d.err = fault;
    // Pulse timing runs regardless of commands
    if (st_q.pw != '0) begin
      st_d.pw = st_q.pw - PW_W'(1);
    end
    if (restart) begin
      // Load and count afresh
      st_d.run    = S_RUN;
      st_d.reload = cmd.init;
      st_d.cnt    = cmd.init;
    end else if (cmd.valid) begin
      // Stop; supplied value ignored
      st_d.run = S_STOP;
    end else if (st_q.run == S_RUN && tick) begin
      if (is_last(st_q.cnt)) begin
        // Count-out: pulse and reload
        st_d.pw  = PW_W'(PULSE_CYC);
        st_d.cnt = st_q.reload;
      end else begin
        st_d.cnt = st_q.cnt - CNT_W'(1);
      end
    end
    st_d.pin_n = (st_d.pw == '0);
    // Low-cycle count, cleared while the line is high
    if (st_d.pin_n) begin
      st_d.low = '0;
    end else begin
      st_d.low = st_q.low + (PW_W+1)'(1);
    end
  end

  // Register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q.run    <= S_STOP;
      st_q.reload <= CNT_RESET;
      st_q.cnt    <= CNT_RESET;
      st_q.pw     <= '0;
      st_q.pin_n  <= 1'b1;
      st_q.err    <= 1'b0;
      st_q.low    <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs from flip-flops
  assign timeout_pulse_n = st_q.pin_n;
  assign status = '{running: (st_q.run == S_RUN),
                    error:   st_q.err};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Tick taken with the counter on its last unit
  sequence s_countout;
    st_q.run == S_RUN && tick && !cmd.valid && is_last(st_q.cnt);
  endsequence

  // Tick taken with more than one unit left
  sequence s_count_step;
    st_q.run == S_RUN && tick && !cmd.valid && !is_last(st_q.cnt);
  endsequence

  // Running with neither tick nor command: count must hold
  sequence s_count_idle;
    st_q.run == S_RUN && !tick && !cmd.valid;
  endsequence

  // Count-out launches the low pulse on the next cycle
  a_pulse_start : assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_countout |=> !timeout_pulse_n)
    else $error("count-out gave no low pulse");

  // Pulse is never a glitch
  a_pulse_width : assert property (
    @(posedge core_clk) disable iff (!resetn)
    $fell(timeout_pulse_n) |-> !timeout_pulse_n [*8])
    else $error("timeout pulse too short");

  // Full pulse length, counted by the low-cycle helper
  a_pulse_exact : assert property (
    @(posedge core_clk) disable iff (!resetn)
    $rose(timeout_pulse_n) && $past(resetn)
      |-> $past(st_q.low) == (PW_W+1)'(PULSE_CYC))
    else $error("timeout pulse length wrong");

  // Line released once the pulse counter runs out
  a_pulse_end : assert property (
    @(posedge core_clk) disable iff (!resetn)
    (st_q.pw == PW_W'(1)) |=> timeout_pulse_n)
    else $error("timeout line not released");

  // Line is low only while a pulse is timed
  a_line_idle : assert property (
    @(posedge core_clk) disable iff (!resetn)
    timeout_pulse_n == (st_q.pw == '0))
    else $error("timeout line low outside a pulse");

  // Count-out reloads the last written value
  a_reload : assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_countout |=> st_q.cnt == $past(st_q.reload))
    else $error("counter did not reload");

  // Counting carries on after count-out
  a_keep_run : assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_countout |=> status.running)
    else $error("counting stopped after count-out");

  // One unit off per tick
  a_count_step : assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_count_step |=> st_q.cnt == $past(st_q.cnt) - CNT_W'(1))
    else $error("counter did not step on tick");

  // No movement between ticks
  a_count_hold : assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_count_idle |=> st_q.cnt == $past(st_q.cnt))
    else $error("counter moved without tick");

  // Start loads the value and runs
  a_start_load : assert property (
    @(posedge core_clk) disable iff (!resetn)
    restart |=> st_q.cnt == $past(cmd.init) && status.running)
    else $error("start did not load value");

  // Stop halts and freezes the count
  a_stop_halt : assert property (
    @(posedge core_clk) disable iff (!resetn)
    is_stop(cmd) |=> !status.running && st_q.cnt == $past(st_q.cnt))
    else $error("stop did not halt counter");

  // Stop leaves the stored initial value alone
  a_stop_keeps : assert property (
    @(posedge core_clk) disable iff (!resetn)
    is_stop(cmd) |=> st_q.reload == $past(st_q.reload))
    else $error("stop changed stored value");

  // No new pulse while halted
  a_stopped_quiet : assert property (
    @(posedge core_clk) disable iff (!resetn)
    !status.running && st_q.pw == '0 |=> timeout_pulse_n)
    else $error("pulse while stopped");

  // Running flag changes only on a command
  a_run_hold : assert property (
    @(posedge core_clk) disable iff (!resetn)
    !cmd.valid |=> status.running == $past(status.running))
    else $error("running flag changed without command");

  // Fault shows one cycle later
  a_error_flag : assert property (
    @(posedge core_clk) disable iff (!resetn)
    fault |=> status.error)
    else $error("fault not reported");

  // Error clears once the fault is gone
  a_error_clear : assert property (
    @(posedge core_clk) disable iff (!resetn)
    !fault |=> !status.error)
    else $error("error flag stuck");

endmodule
`default_nettype wire

/* File: test/host_irq_model.sv */
// Model of the host interrupt input fed by the timeout line.
// Assumes the line is driven by the device on the same core clock.
`timescale 1ns/1ns
`default_nettype none
module host_irq_model (
  input wire logic core_clk, // Core clock
  input wire logic irq_n     // Timeout line, low is a request
);
  int   cyc      = 0;    // Free-running edge count
  int   falls    = 0;    // Requests seen
  int   fall_cyc = 0;    // Edge of the last falling edge
  int   gap      = 0;    // Edges between the last two requests
  int   width    = 0;    // Low edges of the last request
  logic prev     = 1'b1; // Line level one edge ago
  // Latch every low pulse as one request
  always @(posedge core_clk) begin
    cyc  <= cyc + 1;
    prev <= irq_n;
    if (prev === 1'b1 && irq_n === 1'b0) begin
      falls    <= falls + 1;
      gap      <= cyc - fall_cyc;
      fall_cyc <= cyc;
    end
    if (prev === 1'b0 && irq_n === 1'b1) width <= cyc - fall_cyc;
  end
endmodule
`default_nettype wire

/* File: test/tb_watchdog_pulse_timer.sv */
// Self-checking bench for the watchdog pulse timer.
// Assumes short tick and pulse counts set through parameters.
`timescale 1ns/1ns
`default_nettype none
module tb_watchdog_pulse_timer;
  import wdt_pkg::*;
  localparam int TK = 10; // Cycles per unit
  localparam int PW = 9;  // Pulse cycles
  logic        core_clk, resetn, fault, timeout_pulse_n;
  wdt_cmd_s    cmd;
  wdt_stat_s   status;
  int          miscompares = 0, total_checks = 0, n, t0, f, p;
  logic [31:0] rng = 32'h000138a9; // Random state, seed 80041

  watchdog_pulse_timer #(.TICK_CYC(TK), .PULSE_CYC(PW)) dut (
    .core_clk(core_clk), .resetn(resetn), .cmd(cmd), .fault(fault),
    .status(status), .timeout_pulse_n(timeout_pulse_n));
  host_irq_model host (.core_clk(core_clk), .irq_n(timeout_pulse_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Count-out spacing for an initial value; zero acts as one
  function automatic int exp_period(input int u);
    return (u == 0 ? 1 : u) * TK;
  endfunction
  // Value compare
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
    end
  endtask
  // Timing window compare
  task automatic chk_rng(string what, int lo, int hi, int got);
    total_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED %s exp %0d..%0d got %0d", what, lo, hi, got);
    end
  endtask
  // One-cycle command strobe, taken at the second edge
  task automatic send(logic m, logic [15:0] v);
    @(posedge core_clk);
    #5 cmd = '{1'b1, m, v};
    @(posedge core_clk);
    #5 cmd.valid = 1'b0;
  endtask
  // Bounded wait for the next request at the host
  task automatic wait_fall(int lim);
    int c;
    c = host.falls;
    repeat (lim) begin
      @(posedge core_clk);
      #1;
      if (host.falls != c) break;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard
  initial begin
    #(50 * 6000);
    miscompares++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    cmd = '0;
    fault = 1'b0;
    resetn = 1'b0;
    repeat (5) @(posedge core_clk);
    #5 resetn = 1'b1;
    chk("idle line", 1, timeout_pulse_n);
    chk("running", 0, status.running);
    // Corner values 1 and 0 first, then random periods
    for (int i = 0; i < 5; i++) begin
      rng = xs(rng);
      n = (i == 0) ? 1 : (i == 1) ? 0 : int'(rng[2:0]) + 2;
      p = exp_period(n);
      send(MODE_START, 16'(n));
      t0 = host.cyc - 1;
      chk("running", 1, status.running);
      wait_fall(p + 10);
      chk_rng("first", p, p + 3, host.fall_cyc - t0);
      wait_fall(p + 10);
      chk("period", p, host.gap);
      repeat (PW + 2) @(posedge core_clk);
      chk("width", PW, host.width);
    end
    // Timely restarts keep the line quiet
    rng = xs(rng);
    n = int'(rng[3:0]) + 4;
    send(MODE_START, 16'(n));
    f = host.falls;
    repeat (5) begin
      repeat (n * TK / 2) @(posedge core_clk);
      send(MODE_START, 16'(n));
    end
    chk("restart quiet", f, host.falls);
    // Stop with a junk value
    rng = xs(rng);
    send(MODE_STOP, rng[15:0] | 16'h0001);
    f = host.falls;
    chk("running", 0, status.running);
    repeat (300) @(posedge core_clk);
    chk("stop quiet", f, host.falls);
    chk("idle line", 1, timeout_pulse_n);
    // Fault marks status invalid
    @(posedge core_clk);
    #5 fault = 1'b1;
    @(posedge core_clk);
    #1 chk("error", 1, status.error);
    #4 fault = 1'b0;
    @(posedge core_clk);
    #1 chk("error", 0, status.error);
    wrap_up();
  end
endmodule
`default_nettype wire
